// ---- rtl/sfdl_pkg.sv ----
// Purpose: shared constants, types and helpers for the supply fault detector logic
// Assumes: supply samples arrive as millivolt codes, one per input channel
// Notes: channels 0-2 positive, 3 high voltage, 4-7 dual function
package sfdl_pkg;

   // ****************************************
   // sizes and timing
   // ****************************************
   localparam int NCH = 8;
   localparam int NDUAL = 4;
   localparam int NDET = 12;
   localparam int SMP_W = 15;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam int CNT_W = 14;
   localparam int CLK_PERIOD_NS = 8;
   localparam int GF_UNIT_NS = 1000;
   localparam int US_CYC_DEF = (GF_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] GF_MAX_US = 7'h64;
   localparam logic [25:0] STEP_DIV = 26'h00000ff;
   localparam logic [3:0] CH_HV = 4'h3;
   localparam logic [3:0] CH_DUAL_FIRST = 4'h4;

   // ****************************************
   // ranges in millivolts: bottom and span
   // ****************************************
   localparam logic [1:0] RNG_LOW = 2'h0;
   localparam logic [1:0] RNG_MID = 2'h1;
   localparam logic [1:0] RNG_6V = 2'h2;
   localparam logic [1:0] RNG_HV = 2'h3;
   localparam logic [13:0] RB_LOW_MV = 14'h023d;
   localparam logic [13:0] RS_LOW_MV = 14'h0322;
   localparam logic [13:0] RB_MID_MV = 14'h04e2;
   localparam logic [13:0] RS_MID_MV = 14'h06d6;
   localparam logic [13:0] RB_6V_MV = 14'h09c4;
   localparam logic [13:0] RS_6V_MV = 14'h0dac;
   localparam logic [13:0] RB_HV_MV = 14'h1770;
   localparam logic [13:0] RS_HV_MV = 14'h20d0;

   // ****************************************
   // fault types
   // ****************************************
   localparam logic [1:0] FT_UV = 2'h0;
   localparam logic [1:0] FT_OV = 2'h1;
   localparam logic [1:0] FT_WIN = 2'h2;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [1:0] FLD_CTRL = 2'h0;
   localparam logic [1:0] FLD_THR = 2'h1;
   localparam logic [1:0] FLD_HG = 2'h2;
   localparam logic [ADDR_W-1:0] REG_FLT_STAT = 6'h20;
   localparam logic [ADDR_W-1:0] REG_WARN_STAT = 6'h21;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_DIG_BIT = 1;
   localparam int CTRL_FT_LSB = 2;
   localparam int CTRL_RS_LSB = 4;
   localparam int THR_UV_LSB = 0;
   localparam int THR_OV_LSB = 8;
   localparam int HG_HYS_LSB = 0;
   localparam int HG_GF_LSB = 8;

   typedef struct packed {
      logic enable;
      logic digital;
      logic [1:0] ftype;
      logic [1:0] rsel;
      logic [7:0] uv_th;
      logic [7:0] ov_th;
      logic [4:0] hyst;
      logic [6:0] gf_us;
   } sfdl_cfg_s;

   localparam sfdl_cfg_s CFG_RST = '0;

   typedef struct packed {
      logic [NCH-1:0] ov;
      logic [NCH-1:0] uv;
   } sfdl_flags_s;

   typedef struct packed {
      logic [NDUAL-1:0] ov;
      logic [NDUAL-1:0] uv;
   } sfdl_warn_s;

   function automatic logic [13:0] sfdl_bot(input logic [1:0] r);
      unique case (r)
         RNG_LOW: return RB_LOW_MV;
         RNG_MID: return RB_MID_MV;
         RNG_6V: return RB_6V_MV;
         RNG_HV: return RB_HV_MV;
      endcase
   endfunction : sfdl_bot

   function automatic logic [13:0] sfdl_span(input logic [1:0] r);
      unique case (r)
         RNG_LOW: return RS_LOW_MV;
         RNG_MID: return RS_MID_MV;
         RNG_6V: return RS_6V_MV;
         RNG_HV: return RS_HV_MV;
      endcase
   endfunction : sfdl_span

   // illegal choices fall back to the lowest legal range of that input
   function automatic logic [1:0] sfdl_eff_range(input logic [3:0] ch, input logic [1:0] sel);
      if (ch >= CH_DUAL_FIRST) return RNG_LOW;
      if (ch == CH_HV) return (sel == RNG_HV) ? RNG_HV : RNG_6V;
      return (sel == RNG_HV) ? RNG_LOW : sel;
   endfunction : sfdl_eff_range

endpackage : sfdl_pkg

// ---- rtl/sfdl_glitch_filter.sv ----
// Purpose: time-domain filter on one comparator result
// Assumes: limit is the timeout in clock cycles, held steady while counting
// Notes: counts cycles, not a coarse tick, so short pulses never slip through
`timescale 1ns/1ns
`default_nettype none
module sfdl_glitch_filter #(
   parameter int CW = sfdl_pkg::CNT_W
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [CW-1:0] limit,
   input wire logic raw,
   output logic filt
);
   import sfdl_pkg::*;

   // ****************************************
   // counter and output
   // ****************************************
   logic [CW-1:0] cnt;
   logic [CW:0] run;
   wire differ = raw != filt;
   assign run = {1'b0, cnt} + {{CW{1'b0}}, 1'b1};
   wire expire = differ && (run >= {1'b0, limit});

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt <= '0;
         filt <= 1'b0;
      end else if (!differ || expire) begin
         cnt <= '0; // [R16]
         filt <= expire ? raw : filt; // [R14]
      end else begin
         cnt <= run[CW-1:0]; // [R16]
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_filt_short_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
      (filt != $past(filt)) |-> ($past(run) >= {1'b0, $past(limit)})) // [R13]
      else $error("filter passed a pulse shorter than the timeout");
   a_filt_restart: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!differ) |=> (cnt == '0)) // [R16]
      else $error("filter count not restarted");
   a_filt_zero_pass: assert property (@(posedge core_clk) disable iff (sys_rst)
      (differ && limit == '0) |=> (filt == $past(raw))) // [R12]
      else $error("zero timeout did not pass the input");
   c_filt_delay: cover property (@(posedge core_clk) disable iff (sys_rst)
      (limit > 1) && differ ##1 differ ##1 (filt != $past(filt)));

endmodule : sfdl_glitch_filter
`default_nettype wire

// ---- rtl/sfdl_supply_fault_detector.sv ----
// Purpose: digital back-end of eight supply fault detectors with four warning detectors
// Assumes: each input arrives as a synchronous millivolt sample; registers on a plain port
// Notes: compares in scaled integers, so no divider sits in the datapath
// Notes on behaviour
// R1 - eight channels: four dedicated detectors, four dual-function analog or logic inputs
// R2 - a dual channel is either analog detector or digital input, never both
// R3 - each detector reports undervoltage only, overvoltage only, or out-of-window
// R4 - undervoltage and overvoltage thresholds are 8-bit codes, 256 steps
// R5 - trip voltage is range bottom plus span times code over 255
// R6 - four ranges with fixed bottom and span pairs drive the mapping
// R7 - legal ranges depend on channel kind; dual inputs have only the lowest
// R8 - both comparisons run continuously whatever fault type is chosen
// R9 - undervoltage clears only above threshold plus hysteresis
// R10 - overvoltage clears only below threshold minus hysteresis
// R11 - 5-bit hysteresis code, span times code over 255, only once out of tolerance
// R12 - every comparator output passes a glitch filter of 0 to 100 us
// R13 - pulses shorter than the timeout never reach the filtered output
// R14 - longer pulses pass, delayed by the timeout
// R15 - a digital dual channel's detector warns on its paired dedicated input
// R16 - filter counts while result differs, restarts when it returns
// R17 - filtered flags go out, held inactive when disabled or digital
`timescale 1ns/1ns
`default_nettype none
module sfdl_supply_fault_detector #(
   parameter int US_CYC = sfdl_pkg::US_CYC_DEF
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [sfdl_pkg::NCH-1:0][sfdl_pkg::SMP_W-1:0] sample_mv,
   input wire logic [sfdl_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [sfdl_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [sfdl_pkg::DATA_W-1:0] reg_rdata,
   output sfdl_pkg::sfdl_flags_s fault,
   output sfdl_pkg::sfdl_warn_s warn,
   output logic warn_any,
   output logic [sfdl_pkg::NDUAL-1:0] dig_sel
);
   import sfdl_pkg::*;

   localparam logic [CNT_W-1:0] US_CYC_C = CNT_W'(US_CYC);

   // ****************************************
   // register decode
   // ****************************************
   function automatic logic cfg_hit(input logic [ADDR_W-1:0] a);
      return (a[ADDR_W-1] == 1'b0) && (a[1:0] != 2'h3);
   endfunction : cfg_hit

   function automatic logic [DATA_W-1:0] cfg_word(input sfdl_cfg_s c, input logic [1:0] f);
      logic [DATA_W-1:0] w;
      w = '0;
      unique case (f)
         FLD_CTRL: begin
            w[CTRL_EN_BIT] = c.enable;
            w[CTRL_DIG_BIT] = c.digital;
            w[CTRL_FT_LSB +: 2] = c.ftype;
            w[CTRL_RS_LSB +: 2] = c.rsel;
         end
         FLD_THR: begin
            w[THR_UV_LSB +: 8] = c.uv_th;
            w[THR_OV_LSB +: 8] = c.ov_th;
         end
         FLD_HG: begin
            w[HG_HYS_LSB +: 5] = c.hyst;
            w[HG_GF_LSB +: 7] = c.gf_us;
         end
         default: w = '0;
      endcase
      return w;
   endfunction : cfg_word

   sfdl_cfg_s cfg [NCH];
   sfdl_cfg_s cur_cfg;
   sfdl_cfg_s next_cfg;
   wire [2:0] wr_ch = reg_addr[4:2];
   wire [1:0] wr_fld = reg_addr[1:0];
   wire cfg_we = reg_wr && cfg_hit(reg_addr);
   assign cur_cfg = cfg[wr_ch];

   always_comb begin
      next_cfg = cur_cfg;
      unique case (wr_fld)
         FLD_CTRL: begin
            next_cfg.enable = reg_wdata[CTRL_EN_BIT];
            // dedicated channels cannot become logic inputs
            next_cfg.digital = reg_wdata[CTRL_DIG_BIT] && wr_ch[2]; // [R1] [R2]
            next_cfg.ftype = reg_wdata[CTRL_FT_LSB +: 2];
            next_cfg.rsel = reg_wdata[CTRL_RS_LSB +: 2];
         end
         FLD_THR: begin
            next_cfg.uv_th = reg_wdata[THR_UV_LSB +: 8]; // [R4]
            next_cfg.ov_th = reg_wdata[THR_OV_LSB +: 8]; // [R4]
         end
         FLD_HG: begin
            next_cfg.hyst = reg_wdata[HG_HYS_LSB +: 5]; // [R11]
            next_cfg.gf_us = reg_wdata[HG_GF_LSB +: 7];
         end
         default: next_cfg = cur_cfg;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NCH; i++) cfg[i] <= CFG_RST;
      end else if (cfg_we) begin
         cfg[wr_ch] <= next_cfg;
      end
   end

   // ****************************************
   // read back
   // ****************************************
   logic [DATA_W-1:0] rd_word;
   wire [DATA_W-1:0] flt_word = {fault.ov, fault.uv};
   wire [DATA_W-1:0] warn_word = {8'h00, warn.ov, warn.uv};
   assign rd_word = cfg_hit(reg_addr) ? cfg_word(cfg[reg_addr[4:2]], reg_addr[1:0]) :
                    (reg_addr == REG_FLT_STAT) ? flt_word : // [R17]
                    (reg_addr == REG_WARN_STAT) ? warn_word : '0;

   always_ff @(posedge core_clk) begin
      if (sys_rst) reg_rdata <= '0;
      else reg_rdata <= reg_rd ? rd_word : '0;
   end

   // ****************************************
   // detectors: 0-7 primary, 8-11 secondary warning
   // ****************************************
   logic [NDET-1:0] uv_trip, uv_clear, ov_trip, ov_clear;
   logic [NDET-1:0] uv_cmp, ov_cmp, uv_filt, ov_filt;
   logic [NDET-1:0] active, uv_rep, ov_rep;
   logic [NDET-1:0] next_uv, next_ov;
   logic [NDET-1:0][1:0] rng;
   logic [NCH-1:0][CNT_W-1:0] gf_lim;

   // timeout saturates at the documented maximum
   for (genvar c = 0; c < NCH; c++) begin : g_lim
      wire [6:0] us = (cfg[c].gf_us > GF_MAX_US) ? GF_MAX_US : cfg[c].gf_us; // [R12]
      assign gf_lim[c] = CNT_W'(us * US_CYC_C); // [R14]
   end

   for (genvar d = 0; d < NDET; d++) begin : g_det
      localparam int SRC = (d < NCH) ? d : d - NCH;
      localparam int CFG = (d < NCH) ? d : d - NDUAL;
      logic signed [25:0] lhs, uv_lo, uv_hi, ov_hi, ov_lo;
      logic [13:0] vb, vr;
      sfdl_cfg_s c;
      assign c = cfg[CFG];
      // secondary detectors borrow the range of the primary they shadow
      assign rng[d] = sfdl_eff_range(4'(SRC), cfg[SRC].rsel); // [R7] [R15]
      assign vb = sfdl_bot(rng[d]); // [R6]
      assign vr = sfdl_span(rng[d]); // [R6]
      // compare 255*(v-vb) against span*code instead of dividing
      assign lhs = 26'($signed({11'h000, sample_mv[SRC]}) - $signed({12'h000, vb}))
                   * $signed(STEP_DIV); // [R5]
      assign uv_lo = $signed({12'h000, vr}) * $signed({18'h00000, c.uv_th}); // [R5]
      assign uv_hi = $signed({12'h000, vr}) * $signed({18'h00000, c.uv_th} + {21'h000000, c.hyst});
      assign ov_hi = $signed({12'h000, vr}) * $signed({18'h00000, c.ov_th}); // [R5]
      assign ov_lo = $signed({12'h000, vr}) * ($signed({18'h00000, c.ov_th})
                     - $signed({21'h000000, c.hyst}));
      assign uv_trip[d] = lhs < uv_lo; // [R8]
      assign ov_trip[d] = lhs > ov_hi; // [R8]
      assign uv_clear[d] = lhs > uv_hi; // [R9] [R11]
      assign ov_clear[d] = lhs < ov_lo; // [R10] [R11]

      // hysteresis only widens the band once the fault is already set
      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            uv_cmp[d] <= 1'b0;
            ov_cmp[d] <= 1'b0;
         end else begin
            uv_cmp[d] <= uv_cmp[d] ? !uv_clear[d] : uv_trip[d]; // [R9]
            ov_cmp[d] <= ov_cmp[d] ? !ov_clear[d] : ov_trip[d]; // [R10]
         end
      end

      sfdl_glitch_filter #(.CW(CNT_W)) u_uv_filt (
         .core_clk(core_clk),
         .sys_rst(sys_rst),
         .limit(gf_lim[CFG]),
         .raw(uv_cmp[d]),
         .filt(uv_filt[d])
      ); // [R12]
      sfdl_glitch_filter #(.CW(CNT_W)) u_ov_filt (
         .core_clk(core_clk),
         .sys_rst(sys_rst),
         .limit(gf_lim[CFG]),
         .raw(ov_cmp[d]),
         .filt(ov_filt[d])
      ); // [R12]

      if (d < NCH) begin : g_pri
         assign active[d] = c.enable && !c.digital; // [R2] [R17]
      end else begin : g_sec
         assign active[d] = c.enable && c.digital; // [R15]
      end
      assign uv_rep[d] = c.ftype != FT_OV; // [R3]
      assign ov_rep[d] = c.ftype != FT_UV; // [R3]
      assign next_uv[d] = active[d] && uv_rep[d] && uv_filt[d]; // [R17]
      assign next_ov[d] = active[d] && ov_rep[d] && ov_filt[d]; // [R17]
   end

   // ****************************************
   // output flags
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         fault <= '0;
         warn <= '0;
         warn_any <= 1'b0;
         dig_sel <= '0;
      end else begin
         fault.uv <= next_uv[NCH-1:0]; // [R17]
         fault.ov <= next_ov[NCH-1:0]; // [R17]
         warn.uv <= next_uv[NDET-1:NCH]; // [R15]
         warn.ov <= next_ov[NDET-1:NCH]; // [R15]
         warn_any <= |{next_uv[NDET-1:NCH], next_ov[NDET-1:NCH]}; // [R15]
         for (int k = 0; k < NDUAL; k++) dig_sel[k] <= cfg[NDUAL+k].digital; // [R2]
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_rd_one_cycle: assert property (reg_rd && reg_addr == REG_FLT_STAT |=>
      reg_rdata == $past(flt_word) ##1 (reg_rdata == '0 || $past(reg_rd))) // [R17]
      else $error("status read data wrong or not one cycle");
   a_dig_no_fault: assert property (cfg[4].digital |=> !fault.uv[4] && !fault.ov[4]) // [R2]
      else $error("digital input reported an analog fault");
   a_uv_only_mask: assert property (cfg[0].ftype == FT_UV |=> !fault.ov[0]) // [R3]
      else $error("overvoltage reported in undervoltage-only mode");
   a_cmp_always_on: assert property (cfg[0].ftype == FT_OV && uv_trip[0] && !uv_cmp[0]
      |=> uv_cmp[0]) // [R8]
      else $error("undervoltage compare idle in overvoltage mode");
   a_uv_hyst_hold: assert property ($fell(uv_cmp[0]) |-> $past(uv_clear[0])) // [R9]
      else $error("undervoltage cleared inside hysteresis band");
   a_ov_hyst_hold: assert property ($fell(ov_cmp[3]) |-> $past(ov_clear[3])) // [R10]
      else $error("overvoltage cleared inside hysteresis band");
   a_hyst_band: assert property (uv_clear[1] |-> !uv_trip[1]) // [R11]
      else $error("hysteresis clear level below trip level");
   a_gf_limit: assert property (gf_lim[2] <= CNT_W'(GF_MAX_US * US_CYC_C)) // [R12]
      else $error("glitch timeout above maximum");
   a_sec_gated: assert property (warn.uv[0] || warn.ov[0] |->
      $past(cfg[4].enable && cfg[4].digital)) // [R15]
      else $error("warning without digital dual channel");
   a_range_legal: assert property (rng[3][1] && rng[4] == RNG_LOW && rng[11] == rng[3]) // [R7]
      else $error("illegal range in use");
   a_flag_delay: assert property (!active[0] |=> !fault.uv[0] && !fault.ov[0]) // [R17]
      else $error("disabled channel shows a fault");

   c_uv_fault: cover property (!fault.uv[0] ##1 fault.uv[0]);
   c_ov_fault: cover property (!fault.ov[3] ##1 fault.ov[3]);
   c_warning: cover property (warn_any);
   c_hyst_release: cover property (cfg[0].hyst != '0 ##0 $fell(uv_cmp[0]));

endmodule : sfdl_supply_fault_detector
`default_nettype wire

// ---- verif/sfdl_rail_model.sv ----
// Purpose: behavioural model of the supervised supply rails feeding the detector
// Assumes: the bench commands one rail level at a time, applied at the next clock edge
// Notes: every rail rests at IDLE_MV after reset, inside all ch0-2 test windows
`timescale 1ns/1ns
`default_nettype none
module sfdl_rail_model #(
   parameter logic [14:0] IDLE_MV = 15'h03e8
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic set_en,
   input wire logic [2:0] set_ch,
   input wire logic [14:0] set_mv,
   output logic [sfdl_pkg::NCH-1:0][sfdl_pkg::SMP_W-1:0] sample_mv
);
   import sfdl_pkg::*;
   // steps are instant: a rail that slews would hide the exact pulse widths
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sample_mv <= {NCH{IDLE_MV}};
      end else if (set_en) begin
         sample_mv[set_ch] <= set_mv;
      end
   end
endmodule : sfdl_rail_model
`default_nettype wire

// ---- verif/test_supply_fault_detector_logic.sv ----
// Purpose: self-checking bench for the supply fault detector logic
// Assumes: US_CYC shortened to 2, so a 3 us glitch timeout is 6 cycles
// Notes: latencies are judged relative to the measured zero-timeout latency
`timescale 1ns/1ns
`default_nettype none
module test_supply_fault_detector_logic;
   import sfdl_pkg::*;
   localparam int US = 2;
   logic core_clk;
   logic sys_rst;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic [NCH-1:0][SMP_W-1:0] sample_mv;
   sfdl_flags_s fault;
   sfdl_warn_s warn;
   logic warn_any;
   logic [NDUAL-1:0] dig_sel;
   logic set_en;
   logic [2:0] set_ch;
   logic [14:0] set_mv;
   wire logic [23:0] obs = {warn, fault};
   int n_fail = 0;
   int checks = 0;
   int lat0 = 0;

   sfdl_rail_model sfdl_rail_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .set_en(set_en),
      .set_ch(set_ch), .set_mv(set_mv), .sample_mv(sample_mv));
   sfdl_supply_fault_detector #(.US_CYC(US)) sfdl_supply_fault_detector_i (
      .core_clk(core_clk), .sys_rst(sys_rst), .sample_mv(sample_mv), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .fault(fault), .warn(warn), .warn_any(warn_any), .dig_sel(dig_sel));

   always #4 core_clk = ~core_clk;

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic close_out;
      if (n_fail == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask : rd

   // control goes last so a channel never runs on half-written thresholds
   task automatic cfg(input logic [3:0] ch, input logic [15:0] c, input logic [15:0] t,
                      input logic [15:0] h);
      wr({ch, 2'h1}, t);
      wr({ch, 2'h2}, h);
      wr({ch, 2'h0}, c);
   endtask : cfg

   task automatic rail(input logic [2:0] ch, input logic [14:0] mv);
      @(posedge core_clk);
      set_en <= 1'b1;
      set_ch <= ch;
      set_mv <= mv;
      @(posedge core_clk);
      set_en <= 1'b0;
   endtask : rail

   task automatic pulse(input logic [2:0] ch, input logic [14:0] lo, input logic [14:0] hi,
                        input int n);
      rail(ch, lo);
      repeat (n - 2) @(posedge core_clk);
      rail(ch, hi);
   endtask : pulse

   task automatic lat(input int idx, input logic v, output int n);
      n = 0;
      #1;
      while (obs[idx] !== v && n < 400) begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask : lat

   task automatic hold(input int idx, input logic v, input int n);
      repeat (n) begin
         @(posedge core_clk);
         #1;
         chk(24'(obs[idx]), 24'(v));
      end
   endtask : hold

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      chk({obs[23:4], dig_sel}, 24'h0);
      rd(REG_FLT_STAT, 16'h0000);
      rd(6'h1f, 16'h0000);
      wr(6'h23, 16'hffff);
      rd(6'h23, 16'h0000);
      wr(6'h00, 16'h0003);
      rd(6'h00, 16'h0001);
      wr(6'h00, 16'h0000);
   endtask : t_reset

   task automatic t_uv;
      int n;
      cfg(4'h0, 16'h0001, 16'hc864, 16'h000a);
      rail(3'h0, 15'h0378);
      hold(0, 1'b0, 6);
      rail(3'h0, 15'h0377);
      lat(0, 1'b1, lat0);
      chk(24'(lat0 > 1 && lat0 < 4), 24'h1);
      chk(obs, 24'h000001);
      rd(REG_FLT_STAT, 16'h0001);
      rail(3'h0, 15'h0396);
      hold(0, 1'b1, 8);
      rail(3'h0, 15'h0397);
      lat(0, 1'b0, n);
      chk(n, lat0);
   endtask : t_uv

   task automatic t_ov;
      int n;
      cfg(4'h1, 16'h0005, 16'hc864, 16'h000a);
      rail(3'h1, 15'h04b2);
      hold(9, 1'b0, 6);
      rail(3'h1, 15'h04b3);
      lat(9, 1'b1, n);
      chk(n, lat0);
      chk(24'(obs[1]), 24'h0);
      rail(3'h1, 15'h0493);
      hold(9, 1'b1, 8);
      rail(3'h1, 15'h0492);
      lat(9, 1'b0, n);
      chk(n, lat0);
   endtask : t_ov

   task automatic t_win;
      int n;
      cfg(4'h2, 16'h0009, 16'hc864, 16'h000a);
      rail(3'h2, 15'h0377);
      lat(2, 1'b1, n);
      chk(n, lat0);
      rail(3'h2, 15'h04b3);
      lat(10, 1'b1, n);
      chk(n, lat0);
      chk(24'(obs[2]), 24'h0);
      rail(3'h2, 15'h03e8);
      lat(10, 1'b0, n);
      chk(n, lat0);
   endtask : t_win

   task automatic t_glitch;
      int n;
      wr(6'h02, 16'h030a);
      pulse(3'h0, 15'h0377, 15'h03e8, 5);
      hold(0, 1'b0, 12);
      pulse(3'h0, 15'h0377, 15'h03e8, 5);
      pulse(3'h0, 15'h0377, 15'h03e8, 5);
      hold(0, 1'b0, 12);
      // a zero timeout already costs one filter cycle, so only timeout-1 is added
      rail(3'h0, 15'h0377);
      lat(0, 1'b1, n);
      chk(n, lat0 + 3 * US - 1);
      rail(3'h0, 15'h03e8);
      lat(0, 1'b0, n);
      chk(n, lat0 + 3 * US - 1);
   endtask : t_glitch

   task automatic t_dual;
      int n;
      cfg(4'h4, 16'h0003, 16'hc864, 16'h000a);
      hold(4, 1'b0, 2);
      chk({20'h0, dig_sel}, 24'h1);
      rail(3'h0, 15'h0377);
      lat(16, 1'b1, n);
      chk(n, lat0);
      chk(24'(warn_any), 24'h1);
      rd(REG_WARN_STAT, 16'h0001);
      rail(3'h4, 15'h0370);
      hold(4, 1'b0, 6);
      wr(6'h10, 16'h0001);
      lat(4, 1'b1, n);
      chk(24'(n < 6), 24'h1);
      chk({20'h0, dig_sel}, 24'h0);
      wr(6'h00, 16'h0000);
      lat(0, 1'b0, n);
      chk(24'(n < 4), 24'h1);
   endtask : t_dual

   task automatic t_range;
      int n;
      rail(3'h3, 15'h27e9);
      cfg(4'h3, 16'h0031, 16'hff80, 16'h0000);
      hold(3, 1'b0, 6);
      rail(3'h3, 15'h27e8);
      lat(3, 1'b1, n);
      chk(n, lat0);
      // a low range is not offered on this input and falls back to 2.5-6.0
      wr(6'h0c, 16'h0001);
      lat(3, 1'b0, n);
      chk(24'(n < 5), 24'h1);
   endtask : t_range

   initial begin
      core_clk = 1'b0;
      sys_rst = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      set_en = 1'b0;
      set_ch = 3'h0;
      set_mv = 15'h0000;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      #1;
      t_reset();
      t_uv();
      t_ov();
      t_win();
      t_glitch();
      t_dual();
      t_range();
      close_out();
   end

   // the whole run needs a few hundred cycles; this is far beyond it
   initial begin
      #400000;
      n_fail++;
      close_out();
   end
endmodule : test_supply_fault_detector_logic
`default_nettype wire
